// File: hw/rtc_timer_consts.svh
// Offsets, field positions and reset values of the RTC countdown timer.
// Assumes byte offsets on an 8-bit register address.
`ifndef RTC_TIMER_CONSTS_SVH
`define RTC_TIMER_CONSTS_SVH

////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define OFS_IRQ_ENABLE 8'h1c
`define OFS_IRQ_RAW 8'h20
`define OFS_IRQ_MASKED 8'h24
`define OFS_IRQ_CLEAR 8'h28
`define OFS_TIMER_VALUE 8'h2c
`define OFS_TIMER_CONTROL 8'h30
`define OFS_LOAD_FIRST 8'h34
`define OFS_LOAD_SECOND 8'h38
`define OFS_PATTERN_LOW 8'h3c
`define OFS_PATTERN_TOP 8'h48

////////////////////////////////////////////////////////////////////////
// Field positions
`define IRQ_WATCH 0
`define IRQ_COUNT 1
`define CTL_ONE_SHOT 0
`define CTL_RUN 1
`define CTL_SELF_START 2
`define CTL_PLEN_LO 4
`define CTL_PLEN_HI 10
`define CTL_CLK_SEL 11
`define CTL_GATE_OVR 12

////////////////////////////////////////////////////////////////////////
// Reset values
`define COUNT_RESET 32'h0fffffff
`define LOAD_RESET 32'h00000000
`define PATTERN_RESET 32'h00000000

`endif

// File: hw/rtc_timer_pkg.sv
// Types of the RTC countdown timer and its pattern store.
// Assumes the constants header is on the include path.
package rtc_timer_pkg;

    // Register state of the timer block, apart from the pattern store words
    typedef struct packed {
        logic slow_meta;
        logic slow_sync;
        logic slow_prev;
        logic trim_meta;
        logic trim_sync;
        logic trim_prev;
        logic one_shot;
        logic run;
        logic self_start;
        logic [6:0] plen;
        logic clk_sel;
        logic gate_ovr;
        logic [1:0] irq_en;
        logic [1:0] raw;
        logic [31:0] load_first;
        logic [31:0] load_second;
        logic [31:0] count;
        logic [6:0] ptr;
        logic [31:0] rdata;
        logic rd_pat;
    } timer_state_type;

    // Four pattern words plus two registered read ports
    typedef struct packed {
        logic [3:0][31:0] words;
        logic [31:0] rd_data;
        logic [31:0] ptr_word;
    } pattern_state_type;

endpackage

// File: hw/pattern_store.sv
// Four-word reload pattern memory with two registered read ports.
// Assumes one writer on the system clock; reads settle one cycle later.
`timescale 1ns/10ps
`default_nettype none
`include "rtc_timer_consts.svh"

module pattern_store (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Write port
    input wire logic wr_en,
    input wire logic [1:0] wr_idx,
    input wire logic [31:0] wr_data,
    // Bus read port
    input wire logic [1:0] rd_idx,
    output logic [31:0] rd_data,
    // Pointer read port
    input wire logic [1:0] ptr_idx,
    output logic [31:0] ptr_word
);

    rtc_timer_pkg::pattern_state_type cur_r;
    rtc_timer_pkg::pattern_state_type cur_nxt;

    // Both read ports are registered, so data lag the index by one cycle
    always_comb begin
        cur_nxt = cur_r;
        if (wr_en) begin
            cur_nxt.words[wr_idx] = wr_data; // [RULE16] [RULE17]
        end
        cur_nxt.rd_data = cur_r.words[rd_idx];
        cur_nxt.ptr_word = cur_r.words[ptr_idx];
    end

    // Every word clears to zero on reset
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cur_r <= '{words: {4{`PATTERN_RESET}}, default: '0}; // [RULE16]
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign rd_data = cur_r.rd_data;
    assign ptr_word = cur_r.ptr_word;

endmodule
`default_nettype wire

// File: hw/rtc_down_timer_irq_unit.sv
// RTC countdown timer with the interrupt status shared with the clockwatch.
// Assumes the 32 kHz and trimmed clocks arrive as asynchronous pins and
// the clockwatch event is a one-cycle pulse on the system clock.
//
// Notes on behaviour
// [RULE1] - Raw status shows watch flag at bit 0, countdown flag at bit 1.
// [RULE2] - Enable bits gate each source; both clear after reset.
// [RULE3] - Masked status is raw status ANDed with its enable bit.
// [RULE4] - Writing one to a clear bit drops that flag; zero does nothing.
// [RULE5] - Periodic mode: at zero raise the flag and reload the counter.
// [RULE6] - One-shot mode: at zero raise the flag and stop counting.
// [RULE7] - Run bit changes act on the next slow clock tick.
// [RULE8] - Stopped counter holds its value; run bit reads back.
// [RULE9] - Writing a load value while stopped sets the run bit.
// [RULE10] - One-shot expiry clears the run bit.
// [RULE11] - With self-start set, any load or pattern write sets run.
// [RULE12] - Control bits 10:4 hold the pattern length.
// [RULE13] - Control bit 11 picks raw 32 kHz or trimmed count clock.
// [RULE14] - Control bit 12 forces the block clock gate always open.
// [RULE15] - Two 32-bit load values at 0x34 and 0x38, reset zero.
// [RULE16] - Pattern bits 31:0 live in a 32-bit register, reset zero.
// [RULE17] - Pattern spans 128 bits over four words, top word 127:96.
// [RULE18] - Each reload picks load value by pattern bit, pointer wraps.
// [RULE19] - Timer value register reads the counter, resets to all ones; the code resets it to 0x0fffffff.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "rtc_timer_consts.svh"

module rtc_down_timer_irq_unit (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    // Count clocks and clockwatch event
    input wire logic slow_32k_clock,
    input wire logic trimmed_clock,
    input wire logic watch_event,
    // Outputs
    output logic irq,
    output logic clock_gate_en
);

    ////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // True for the four pattern word offsets
    function automatic logic is_pattern(input logic [7:0] addr);
        is_pattern = (addr == `OFS_PATTERN_LOW) || (addr == 8'h40) ||
                     (addr == 8'h44) || (addr == `OFS_PATTERN_TOP);
    endfunction

    // Word index: 0x3c maps to 0 through 0x48 mapping to 3
    function automatic logic [1:0] pattern_index(input logic [7:0] addr);
        pattern_index = addr[3:2] + 2'h1;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // State and derived terms

    localparam rtc_timer_pkg::timer_state_type RESET_STATE = '{
        count: `COUNT_RESET, // [RULE19]
        load_first: `LOAD_RESET,
        load_second: `LOAD_RESET,
        default: '0
    };

    rtc_timer_pkg::timer_state_type cur_r;
    rtc_timer_pkg::timer_state_type cur_nxt;

    logic slow_tick;
    logic trim_tick;
    logic count_tick;
    logic expire;
    logic pat_bit;
    logic [31:0] reload_val;
    logic [7:0] ptr_inc;
    logic [6:0] ptr_next;
    logic wr_load;
    logic wr_pat;
    logic [1:0] masked;
    logic [31:0] ctrl_word;
    logic [31:0] mem_rd_data;
    logic [31:0] ptr_word;

    // Edges are taken from the second synchroniser stage only
    assign slow_tick = cur_r.slow_sync & ~cur_r.slow_prev;
    assign trim_tick = cur_r.trim_sync & ~cur_r.trim_prev;
    assign count_tick = cur_r.clk_sel ? trim_tick : slow_tick; // [RULE13]
    assign expire = count_tick & cur_r.run & (cur_r.count == 32'h0);

    // Pattern bit under the pointer chooses the next reload value
    assign pat_bit = ptr_word[cur_r.ptr[4:0]];
    assign reload_val = pat_bit ? cur_r.load_second : cur_r.load_first; // [RULE18]

    // Pointer wraps once it has crossed plen bits; a length of zero acts as one
    assign ptr_inc = {1'b0, cur_r.ptr} + 8'h01;
    assign ptr_next = (ptr_inc >= {1'b0, cur_r.plen}) ? 7'h00 : ptr_inc[6:0]; // [RULE12]

    // Write strobes that may start the counter
    assign wr_load = bus_wr & ((bus_addr == `OFS_LOAD_FIRST) || (bus_addr == `OFS_LOAD_SECOND));
    assign wr_pat = bus_wr & is_pattern(bus_addr);

    // Masked status and the single level interrupt
    assign masked = cur_r.raw & cur_r.irq_en; // [RULE3]
    assign irq = |masked; // [RULE2]

    // Clock gate opens while counting, or always when overridden
    assign clock_gate_en = cur_r.run | cur_r.gate_ovr; // [RULE14]

    // Control register as software sees it; bit 3 and 31:13 read zero
    assign ctrl_word = {19'h0, cur_r.gate_ovr, cur_r.clk_sel, cur_r.plen, 1'b0,
                        cur_r.self_start, cur_r.run, cur_r.one_shot}; // [RULE8] [RULE12]

    ////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        cur_nxt = cur_r;

        // Two-stage synchronisers, then an edge history flop
        cur_nxt.slow_meta = slow_32k_clock;
        cur_nxt.slow_sync = cur_r.slow_meta;
        cur_nxt.slow_prev = cur_r.slow_sync;
        cur_nxt.trim_meta = trimmed_clock;
        cur_nxt.trim_sync = cur_r.trim_meta;
        cur_nxt.trim_prev = cur_r.trim_sync;

        // Clears go first so that a same-cycle event still sets its flag
        if (bus_wr && (bus_addr == `OFS_IRQ_CLEAR)) begin
            cur_nxt.raw = cur_r.raw & ~bus_wdata[1:0]; // [RULE4]
        end
        if (watch_event) begin
            cur_nxt.raw[`IRQ_WATCH] = 1'b1; // [RULE1]
        end

        // Counter moves only on a tick of the chosen clock while running
        if (count_tick && cur_r.run) begin // [RULE7] [RULE8]
            if (cur_r.count == 32'h0) begin
                cur_nxt.raw[`IRQ_COUNT] = 1'b1; // [RULE1] [RULE5] [RULE6]
                cur_nxt.count = reload_val; // [RULE5]
                cur_nxt.ptr = ptr_next; // [RULE18]
                if (cur_r.one_shot) begin
                    cur_nxt.run = 1'b0; // [RULE6] [RULE10]
                end
            end else begin
                cur_nxt.count = cur_r.count - 32'h1;
            end
        end

        // Register writes; a software run write beats a same-cycle expiry
        if (bus_wr) begin
            case (bus_addr)
                `OFS_IRQ_ENABLE: begin
                    cur_nxt.irq_en = bus_wdata[1:0]; // [RULE2]
                end
                `OFS_TIMER_CONTROL: begin
                    cur_nxt.one_shot = bus_wdata[`CTL_ONE_SHOT];
                    cur_nxt.run = bus_wdata[`CTL_RUN]; // [RULE7]
                    cur_nxt.self_start = bus_wdata[`CTL_SELF_START];
                    cur_nxt.plen = bus_wdata[`CTL_PLEN_HI:`CTL_PLEN_LO]; // [RULE12]
                    cur_nxt.clk_sel = bus_wdata[`CTL_CLK_SEL]; // [RULE13]
                    cur_nxt.gate_ovr = bus_wdata[`CTL_GATE_OVR]; // [RULE14]
                end
                // A write to a stopped timer also loads the counter; otherwise the
                // first expiry would only come after the whole reset count
                `OFS_LOAD_FIRST: begin
                    cur_nxt.load_first = bus_wdata; // [RULE15]
                    if (!cur_r.run) begin
                        cur_nxt.count = bus_wdata; // [RULE9]
                    end
                end
                `OFS_LOAD_SECOND: begin
                    cur_nxt.load_second = bus_wdata; // [RULE15]
                    if (!cur_r.run) begin
                        cur_nxt.count = bus_wdata; // [RULE9]
                    end
                end
                default: begin
                end
            endcase
        end

        // Hardware start on load writes while stopped, or on any with self-start
        if ((wr_load && !cur_r.run) || ((wr_load || wr_pat) && cur_r.self_start)) begin
            cur_nxt.run = 1'b1; // [RULE9] [RULE11]
        end

        // Read data land in the cycle after the strobe
        if (bus_rd) begin
            cur_nxt.rd_pat = is_pattern(bus_addr);
            case (bus_addr)
                `OFS_IRQ_ENABLE: cur_nxt.rdata = {30'h0, cur_r.irq_en};
                `OFS_IRQ_RAW: cur_nxt.rdata = {30'h0, cur_r.raw}; // [RULE1]
                `OFS_IRQ_MASKED: cur_nxt.rdata = {30'h0, masked}; // [RULE3]
                `OFS_TIMER_VALUE: cur_nxt.rdata = cur_r.count; // [RULE19]
                `OFS_TIMER_CONTROL: cur_nxt.rdata = ctrl_word; // [RULE8]
                `OFS_LOAD_FIRST: cur_nxt.rdata = cur_r.load_first;
                `OFS_LOAD_SECOND: cur_nxt.rdata = cur_r.load_second;
                default: cur_nxt.rdata = 32'h0;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cur_r <= RESET_STATE;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pattern memory

    // Pointer word lags one cycle; ticks are thousands of cycles apart
    pattern_store u_pattern (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .wr_en(wr_pat),
        .wr_idx(pattern_index(bus_addr)),
        .wr_data(bus_wdata),
        .rd_idx(pattern_index(bus_addr)),
        .rd_data(mem_rd_data),
        .ptr_idx(cur_r.ptr[6:5]),
        .ptr_word(ptr_word)
    );

    // Both sources are flops; the select tracks the last read
    assign bus_rdata = cur_r.rd_pat ? mem_rd_data : cur_r.rdata;

    ////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking dflt_cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    a_raw_read_value: assert property ( // [RULE1]
        bus_rd && (bus_addr == `OFS_IRQ_RAW) |=> bus_rdata == {30'h0, $past(cur_r.raw)})
        else $error("raw status read mismatch");

    a_masked_read_value: assert property ( // [RULE3]
        bus_rd && (bus_addr == `OFS_IRQ_MASKED)
        |=> bus_rdata == {30'h0, $past(cur_r.raw) & $past(cur_r.irq_en)})
        else $error("masked status read mismatch");

    a_disabled_no_irq: assert property ( // [RULE2]
        (cur_r.irq_en == 2'h0) |-> !irq)
        else $error("interrupt with both sources disabled");

    a_clear_one_drops: assert property ( // [RULE4]
        bus_wr && (bus_addr == `OFS_IRQ_CLEAR) && bus_wdata[1] && !expire
        |=> !cur_r.raw[`IRQ_COUNT])
        else $error("countdown flag survived clear");

    a_clear_zero_keeps: assert property ( // [RULE4]
        bus_wr && (bus_addr == `OFS_IRQ_CLEAR) && !bus_wdata[0] && cur_r.raw[0]
        |=> cur_r.raw[`IRQ_WATCH])
        else $error("watch flag lost on zero clear");

    a_periodic_reload: assert property ( // [RULE5]
        expire && !cur_r.one_shot
        |=> (cur_r.count == $past(reload_val)) && cur_r.raw[`IRQ_COUNT])
        else $error("periodic expiry did not reload");

    a_oneshot_stops: assert property ( // [RULE10]
        expire && cur_r.one_shot && !(bus_wr && (bus_addr == `OFS_TIMER_CONTROL))
        && !wr_load && !wr_pat |=> !cur_r.run ##1 ($stable(cur_r.count) || $past(wr_load)))
        else $error("one-shot expiry kept running");

    a_stopped_frozen: assert property ( // [RULE8]
        !cur_r.run && !wr_load |=> $stable(cur_r.count))
        else $error("counter moved while stopped");

    a_count_step: assert property ( // [RULE7]
        count_tick && cur_r.run && (cur_r.count != 32'h0)
        |=> cur_r.count == $past(cur_r.count) - 32'h1)
        else $error("counter did not step down by one");

    a_load_starts: assert property ( // [RULE9]
        wr_load && !cur_r.run |=> cur_r.run)
        else $error("load write while stopped did not start");

    a_load_sets_count: assert property ( // [RULE9]
        wr_load && !cur_r.run |=> cur_r.count == $past(bus_wdata))
        else $error("load write while stopped did not set the counter");

    a_selfstart_run: assert property ( // [RULE11]
        wr_pat && cur_r.self_start |=> cur_r.run)
        else $error("self-start pattern write did not start");

    c_periodic_expiry: cover property (expire && !cur_r.one_shot);
    c_oneshot_expiry: cover property (expire && cur_r.one_shot);
    c_clear_same_event: cover property (
        bus_wr && (bus_addr == `OFS_IRQ_CLEAR) && bus_wdata[0] && watch_event);
    c_second_reload: cover property (expire && pat_bit);

endmodule
`default_nettype wire

// File: bench/test_rtc_down_timer_irq_unit.sv
// Self-checking bench of the RTC countdown timer and its shared interrupt status.
// Assumes the constants header is on the include path and count pins are driven here.
`timescale 1ns/10ps
`default_nettype none
`include "rtc_timer_consts.svh"

module test_rtc_down_timer_irq_unit;

    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h00000000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [31:0] bus_rdata;
    logic slow_32k_clock = 1'b0;
    logic trimmed_clock = 1'b0;
    logic watch_event = 1'b0;
    logic irq;
    logic clock_gate_en;
    int n_errors = 0;
    int total_checks = 0;
    int seed = 20680;
    // Behavioural model state
    logic [31:0] m_count = 32'h0fffffff;
    logic [31:0] m_l1 = 32'h00000000;
    logic [31:0] m_l2 = 32'h00000000;
    logic [3:0][31:0] m_pat = '0;
    logic [1:0] m_raw = 2'h0;
    logic [1:0] m_en = 2'h0;
    logic m_os = 1'b0, m_run = 1'b0, m_ss = 1'b0, m_clk = 1'b0, m_gate = 1'b0;
    logic [6:0] m_plen = 7'h00;
    logic [6:0] m_ptr = 7'h00;

    rtc_down_timer_irq_unit uut (.clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .slow_32k_clock(slow_32k_clock), .trimmed_clock(trimmed_clock), .watch_event(watch_event),
        .irq(irq), .clock_gate_en(clock_gate_en));

    // 125 MHz system clock
    always #4 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////
    // Result reporting
    task automatic conclude();
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Register port master, one-cycle strobes launched after the edge
    task automatic bwr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        // Mirror the write in the model
        case (a)
            `OFS_IRQ_ENABLE: m_en = d[1:0];
            `OFS_IRQ_CLEAR: m_raw = m_raw & ~d[1:0];
            `OFS_TIMER_CONTROL: {m_gate, m_clk, m_plen, m_ss, m_run, m_os} = {d[12:4], d[2:0]};
            `OFS_LOAD_FIRST: begin
                if (!m_run) m_count = d;
                {m_l1, m_run} = {d, 1'b1};
            end
            `OFS_LOAD_SECOND: begin
                if (!m_run) m_count = d;
                {m_l2, m_run} = {d, 1'b1};
            end
            8'h3c, 8'h40, 8'h44, 8'h48: begin
                m_pat[(a - 8'h3c) >> 2] = d;
                m_run = m_run | m_ss;
            end
            default: ;
        endcase
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_sys);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1;
        chk(bus_rdata, exp, what);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One tick on a count pin; the model counts only if that pin is selected
    task automatic tick(input logic sel);
        @(posedge clk_sys);
        if (sel) trimmed_clock <= 1'b1;
        else slow_32k_clock <= 1'b1;
        repeat (6) @(posedge clk_sys);
        trimmed_clock <= 1'b0;
        slow_32k_clock <= 1'b0;
        repeat (6) @(posedge clk_sys);
        if (sel == m_clk && m_run) begin
            if (m_count != 0) begin
                m_count = m_count - 1;
            end else begin
                // Expiry: flag, reload by pattern bit, pointer wraps at the length
                m_raw[1] = 1'b1;
                m_count = m_pat[m_ptr[6:5]][m_ptr[4:0]] ? m_l2 : m_l1;
                m_ptr = (int'(m_ptr) + 1 >= int'(m_plen)) ? 7'h00 : m_ptr + 7'h01;
                if (m_os) m_run = 1'b0;
            end
        end
    endtask

    // Compare every visible result against the model
    task automatic check_all();
        int i;
        rd_chk(`OFS_IRQ_ENABLE, {30'h0, m_en}, "enable");
        rd_chk(`OFS_IRQ_RAW, {30'h0, m_raw}, "raw");
        rd_chk(`OFS_IRQ_MASKED, {30'h0, m_raw & m_en}, "masked");
        rd_chk(`OFS_TIMER_VALUE, m_count, "counter");
        rd_chk(`OFS_TIMER_CONTROL, {19'h0, m_gate, m_clk, m_plen, 1'b0, m_ss, m_run, m_os}, "ctl");
        rd_chk(`OFS_LOAD_FIRST, m_l1, "load1");
        rd_chk(`OFS_LOAD_SECOND, m_l2, "load2");
        for (i = 0; i < 4; i++) begin
            rd_chk(8'h3c + 8'(4 * i), m_pat[i], "pattern");
        end
        chk({31'h0, irq}, {31'h0, |(m_raw & m_en)}, "irq");
        chk({31'h0, clock_gate_en}, {31'h0, m_run | m_gate}, "gate");
    endtask

    // Hang guard
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_errors++;
        $display("unexpected at %0t: run did not finish", $time);
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int k;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        // Reset values, unmapped and write-only places, read-only write ignored
        check_all();
        rd_chk(8'h50, 32'h00000000, "unmapped");
        rd_chk(`OFS_IRQ_CLEAR, 32'h00000000, "clear reads zero");
        bwr(`OFS_TIMER_VALUE, 32'h12345678);
        bwr(`OFS_IRQ_RAW, 32'h00000003);
        check_all();
        $display("test reset done");
        // Watch flag: masked off, then unmasked, zero clear, one clear
        @(posedge clk_sys);
        watch_event <= 1'b1;
        @(posedge clk_sys);
        watch_event <= 1'b0;
        m_raw[0] = 1'b1;
        check_all();
        bwr(`OFS_IRQ_ENABLE, 32'h00000003);
        check_all();
        bwr(`OFS_IRQ_CLEAR, 32'h00000000);
        check_all();
        bwr(`OFS_IRQ_CLEAR, 32'h00000001);
        check_all();
        // Event and clear in one cycle: the set wins
        @(posedge clk_sys);
        watch_event <= 1'b1;
        bus_wr <= 1'b1;
        bus_addr <= `OFS_IRQ_CLEAR;
        bus_wdata <= 32'h00000001;
        @(posedge clk_sys);
        watch_event <= 1'b0;
        bus_wr <= 1'b0;
        m_raw[0] = 1'b1;
        check_all();
        $display("test interrupt done");
        // Load write while stopped starts the count; stop freezes it
        tick(1'b0);
        bwr(`OFS_LOAD_FIRST, 32'(($random(seed) & 32'hff) + 2));
        check_all();
        for (k = 0; k < 5; k++) tick(1'b0);
        check_all();
        bwr(`OFS_TIMER_CONTROL, {19'h0, 1'b0, 1'b0, 7'h05, 4'h1});
        for (k = 0; k < 3; k++) tick(1'b0);
        check_all();
        $display("test run control done");
        // Trimmed clock selected: raw pin ignored
        bwr(`OFS_TIMER_CONTROL, {19'h0, 1'b0, 1'b1, 7'h7f, 4'h2});
        for (k = 0; k < 4; k++) tick(k[0]);
        check_all();
        $display("test clock select done");
        // Pattern writes start only with self-start set
        bwr(`OFS_TIMER_CONTROL, 32'h00000000);
        bwr(8'h48, $random(seed));
        check_all();
        bwr(`OFS_TIMER_CONTROL, 32'h00000004);
        bwr(8'h3c, $random(seed));
        check_all();
        bwr(`OFS_LOAD_SECOND, $random(seed));
        tick(1'b0);
        tick(1'b0);
        check_all();
        $display("test self start done");
        // Gate override alone holds the clock enable on
        bwr(`OFS_TIMER_CONTROL, {19'h0, 1'b1, 12'h000});
        check_all();
        bwr(`OFS_TIMER_CONTROL, 32'h00000000);
        check_all();
        $display("test gating done");
        // Periodic expiries: pattern 0b010 over three bits picks first, then second
        bwr(8'h3c, 32'h00000002);
        bwr(`OFS_TIMER_CONTROL, {19'h0, 2'h0, 7'h03, 4'h0});
        bwr(`OFS_IRQ_CLEAR, 32'h00000003);
        bwr(`OFS_LOAD_SECOND, 32'h00000004);
        bwr(`OFS_LOAD_FIRST, 32'h00000001);
        for (k = 0; k < 9; k++) tick(1'b0);
        check_all();
        $display("test expiry done");
        // One-shot expiry stops the count and drops the run bit
        bwr(`OFS_IRQ_CLEAR, 32'h00000002);
        bwr(`OFS_TIMER_CONTROL, {19'h0, 2'h0, 7'h03, 4'h1});
        bwr(`OFS_LOAD_FIRST, 32'h00000002);
        for (k = 0; k < 4; k++) tick(1'b0);
        check_all();
        $display("test one shot done");
        conclude();
    end

endmodule
`default_nettype wire
